/* common/fuse_defines.vh */
// Offsets, field positions, reset values and size codes of the protection bytes
`ifndef FUSE_DEFINES_VH
`define FUSE_DEFINES_VH

// APB byte addresses (low bits of the configuration space)
`define OFS_DEBUG_BOOT_STACK  12'h018
`define OFS_CODE_BLOCK_LOCK   12'h028
`define OFS_EEPROM_BOOT_LOCK  12'h02c
`define OFS_PROGRAM_MODE      12'h040
`define OFS_WRITE_REQ         12'h044
`define OFS_STATUS            12'h048
// Printed register indices
`define IDX_DEBUG_BOOT_STACK  24'h300006
`define IDX_CODE_BLOCK_LOCK   24'h30000a
`define IDX_EEPROM_BOOT_LOCK  24'h30000b

// debug_boot_stack_config fields
`define BIT_DEBUGGER_OFF      7
`define BIT_EXT_INSN          6
`define BIT_BOOT_SIZE_HI      5
`define BIT_BOOT_SIZE_LO      4
`define BIT_STACK_FAULT_RST   0
`define MASK_DEBUG_BOOT_STACK 8'hf1
`define RST_DEBUG_BOOT_STACK  8'h81
// code_block_lock_config fields
`define BIT_CODE_BLOCK1       1
`define BIT_CODE_BLOCK0       0
`define MASK_CODE_BLOCK_LOCK  8'h03
`define RST_CODE_BLOCK_LOCK   8'h03
// eeprom_boot_config_lock fields
`define BIT_EEPROM_UNLOCKED   7
`define BIT_BOOT_UNLOCKED     6
`define BIT_CONFIG_UNLOCKED   5
`define MASK_EEPROM_BOOT_LOCK 8'he0
`define RST_EEPROM_BOOT_LOCK  8'he0

// Boot block sizes in words
`define BOOT_SIZE_1K          11'h400
`define BOOT_SIZE_512         11'h200
`define BOOT_SIZE_256         11'h100

// Self-write request region codes
`define REGION_CODE0          3'h0
`define REGION_CODE1          3'h1
`define REGION_BOOT           3'h2
`define REGION_EEPROM         3'h3
`define REGION_CONFIG         3'h4

`endif

/* core/write_gate.v */
// Decides whether one self-write or erase to a region is allowed
`timescale 1ns/1ps
`default_nettype none
`include "fuse_defines.vh"

module write_gate (
  input  wire [2:0] region,
  input  wire [1:0] code_locks,
  input  wire       eeprom_unlocked,
  input  wire       boot_region_unlocked,
  input  wire       config_unlocked,
  input  wire       program_mode,
  output reg        allowed
);

  always @* begin
    case (region)
      `REGION_CODE0:  allowed = code_locks[0];                  // [R4]
      `REGION_CODE1:  allowed = code_locks[1];                  // [R4]
      `REGION_BOOT:   allowed = boot_region_unlocked;           // [R6]
      `REGION_EEPROM: allowed = eeprom_unlocked;                // [R5]
      `REGION_CONFIG: allowed = config_unlocked | program_mode; // [R7]
      default:        allowed = 1'b0;
    endcase
  end

endmodule // write_gate

`default_nettype wire

/* core/config_fuse_protection.v */
// Protection and debug configuration bytes with APB access and write gating
// How it works
// [R1] Debugger-off 1 keeps debug off, pins b6/b7 general I/O; 0 dedicates them.
// [R2] Two-bit boot size field picks 1 kW, 512W or 256W per variant.
// [R3] Stack fault reset bit 1 resets on overflow/underflow; 0 never resets.
// [R4] Each code block lock bit at 0 blocks writes to its block.
// [R5] EEPROM lock bit at 0 blocks data EEPROM writes; 1 allows them.
// [R6] Boot region lock bit at 0 blocks boot block writes.
// [R7] Config lock 0 protects config bytes; itself changes only in Program mode.
// [R8] Code, boot and EEPROM lock bits reset to 1 and can only be cleared.
// [R9] Unimplemented positions in these bytes read as zero.
// [R10] Writes or erases to a locked region are dropped, contents unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "fuse_defines.vh"

module config_fuse_protection #(
  parameter LARGE_VARIANT = 1
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        stack_overflow,
  input  wire        stack_underflow,
  output reg         debug_enable,
  output reg         port_pin_b6_gpio,
  output reg         port_pin_b7_gpio,
  output reg  [10:0] boot_block_words,
  output reg         stack_reset,
  output reg         code_block0_wp,
  output reg         code_block1_wp,
  output reg         eeprom_wp,
  output reg         boot_wp,
  output reg         config_wp,
  output reg         self_write_go,
  output reg  [2:0]  self_write_region
);

  // ------------------------------------------------------------
  // Configuration state
  // ------------------------------------------------------------
  reg  [7:0] debug_boot_stack_reg;
  reg  [7:0] code_block_lock_reg;
  reg  [7:0] eeprom_boot_lock_reg;
  reg        program_mode_reg;
  reg        dropped_reg;
  reg  [7:0] drop_count_reg;
  reg  [2:0] pend_region_reg;
  reg        stk_ovf_meta_reg;
  reg        stk_ovf_reg;
  reg        stk_unf_meta_reg;
  reg        stk_unf_reg;

  wire       setup_ph = psel & ~penable;
  wire       wr_ph    = setup_ph & pwrite;
  wire       rd_ph    = setup_ph & ~pwrite;
  wire       cfg_unl  = eeprom_boot_lock_reg[`BIT_CONFIG_UNLOCKED];
  // Normal-mode writes need the configuration unlocked
  wire       cfg_wr_ok = program_mode_reg | cfg_unl; // [R7]
  wire       allowed;

  write_gate u_gate (
    .region               (pwdata[2:0]),
    .code_locks           (code_block_lock_reg[1:0]),
    .eeprom_unlocked      (eeprom_boot_lock_reg[`BIT_EEPROM_UNLOCKED]),
    .boot_region_unlocked (eeprom_boot_lock_reg[`BIT_BOOT_UNLOCKED]),
    .config_unlocked      (cfg_unl),
    .program_mode         (program_mode_reg),
    .allowed              (allowed)
  );

  wire hit_dbs  = (paddr == `OFS_DEBUG_BOOT_STACK);
  wire hit_cbl  = (paddr == `OFS_CODE_BLOCK_LOCK);
  wire hit_ebl  = (paddr == `OFS_EEPROM_BOOT_LOCK);
  wire hit_pm   = (paddr == `OFS_PROGRAM_MODE);
  wire hit_req  = (paddr == `OFS_WRITE_REQ);
  wire hit_st   = (paddr == `OFS_STATUS);
  wire mapped   = hit_dbs | hit_cbl | hit_ebl | hit_pm | hit_req | hit_st;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Writes are taken in the setup cycle; the access cycle always
  // answers ready, so every transfer takes exactly two cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_boot_stack_reg <= `RST_DEBUG_BOOT_STACK;
      code_block_lock_reg  <= `RST_CODE_BLOCK_LOCK;   // [R8]
      eeprom_boot_lock_reg <= `RST_EEPROM_BOOT_LOCK;  // [R8]
      program_mode_reg     <= 1'b0;
      dropped_reg          <= 1'b0;
      drop_count_reg       <= 8'h00;
      pend_region_reg      <= 3'h0;
      self_write_go        <= 1'b0;
      self_write_region    <= 3'h0;
    end else begin
      self_write_go <= 1'b0;
      if (wr_ph && hit_dbs && cfg_wr_ok) begin
        debug_boot_stack_reg <= pwdata[7:0] & `MASK_DEBUG_BOOT_STACK; // [R9]
      end
      if (wr_ph && hit_cbl && cfg_wr_ok) begin
        // Lock bits only ever go from 1 to 0
        code_block_lock_reg <= code_block_lock_reg & pwdata[7:0]
                               & `MASK_CODE_BLOCK_LOCK; // [R8]
      end
      if (wr_ph && hit_ebl && cfg_wr_ok) begin
        eeprom_boot_lock_reg[`BIT_EEPROM_UNLOCKED] <=
          eeprom_boot_lock_reg[`BIT_EEPROM_UNLOCKED] &
          pwdata[`BIT_EEPROM_UNLOCKED]; // [R8]
        eeprom_boot_lock_reg[`BIT_BOOT_UNLOCKED] <=
          eeprom_boot_lock_reg[`BIT_BOOT_UNLOCKED] &
          pwdata[`BIT_BOOT_UNLOCKED]; // [R8]
        if (program_mode_reg) begin
          eeprom_boot_lock_reg[`BIT_CONFIG_UNLOCKED] <=
            pwdata[`BIT_CONFIG_UNLOCKED]; // [R7]
        end
      end
      if (wr_ph && hit_pm) begin
        program_mode_reg <= pwdata[0];
      end
      if (wr_ph && hit_req) begin
        pend_region_reg <= pwdata[2:0];
        if (allowed) begin
          self_write_go     <= 1'b1;
          self_write_region <= pwdata[2:0];
        end else begin
          // Locked target: request vanishes, memory stays intact
          dropped_reg    <= 1'b1; // [R10]
          drop_count_reg <= drop_count_reg + 8'h01;
        end
      end else if (wr_ph && hit_st && pwdata[0]) begin
        dropped_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Read data and bus answer
  // ------------------------------------------------------------
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    case (1'b1)
      hit_dbs: rd_next[7:0] = debug_boot_stack_reg;  // [R9]
      hit_cbl: rd_next[7:0] = code_block_lock_reg;   // [R9]
      hit_ebl: rd_next[7:0] = eeprom_boot_lock_reg;  // [R9]
      hit_pm:  rd_next[0]   = program_mode_reg;
      hit_req: rd_next[2:0] = pend_region_reg;
      hit_st:  rd_next[15:0] = {drop_count_reg, 7'h00, dropped_reg};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (rd_ph) begin
        prdata <= rd_next;
      end
    end
  end

  // ------------------------------------------------------------
  // Stack fault inputs come from the core domain via pins
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stk_ovf_meta_reg <= 1'b0;
      stk_ovf_reg      <= 1'b0;
      stk_unf_meta_reg <= 1'b0;
      stk_unf_reg      <= 1'b0;
    end else begin
      stk_ovf_meta_reg <= stack_overflow;
      stk_ovf_reg      <= stk_ovf_meta_reg;
      stk_unf_meta_reg <= stack_underflow;
      stk_unf_reg      <= stk_unf_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Policy outputs
  // ------------------------------------------------------------
  wire [1:0] bsz = {debug_boot_stack_reg[`BIT_BOOT_SIZE_HI],
                    debug_boot_stack_reg[`BIT_BOOT_SIZE_LO]};
  reg  [10:0] boot_next;
  always @* begin
    boot_next = `BOOT_SIZE_256;
    case (bsz)
      2'b11, 2'b10: boot_next = (LARGE_VARIANT != 0) ?
                                `BOOT_SIZE_1K : `BOOT_SIZE_512; // [R2]
      2'b01:        boot_next = `BOOT_SIZE_512;                 // [R2]
      default:      boot_next = `BOOT_SIZE_256;                 // [R2]
    endcase
  end

  wire dbg_off = debug_boot_stack_reg[`BIT_DEBUGGER_OFF];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_enable     <= 1'b0;
      port_pin_b6_gpio <= 1'b1;
      port_pin_b7_gpio <= 1'b1;
      boot_block_words <= `BOOT_SIZE_256;
      stack_reset      <= 1'b0;
      code_block0_wp   <= 1'b0;
      code_block1_wp   <= 1'b0;
      eeprom_wp        <= 1'b0;
      boot_wp          <= 1'b0;
      config_wp        <= 1'b0;
    end else begin
      debug_enable     <= ~dbg_off; // [R1]
      port_pin_b6_gpio <= dbg_off;  // [R1]
      port_pin_b7_gpio <= dbg_off;  // [R1]
      boot_block_words <= boot_next;
      stack_reset      <= debug_boot_stack_reg[`BIT_STACK_FAULT_RST] &
                          (stk_ovf_reg | stk_unf_reg); // [R3]
      code_block0_wp   <= ~code_block_lock_reg[`BIT_CODE_BLOCK0]; // [R4]
      code_block1_wp   <= ~code_block_lock_reg[`BIT_CODE_BLOCK1]; // [R4]
      eeprom_wp        <= ~eeprom_boot_lock_reg[`BIT_EEPROM_UNLOCKED]; // [R5]
      boot_wp          <= ~eeprom_boot_lock_reg[`BIT_BOOT_UNLOCKED]; // [R6]
      config_wp        <= ~cfg_unl; // [R7]
    end
  end

endmodule // config_fuse_protection

`default_nettype wire

/* verif/fuse_props.sv */
// Port-level assertions for the protection configuration block
`timescale 1ns/1ps
`default_nettype none
module fuse_props #(
  parameter LARGE_VARIANT = 1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stack_overflow,
  input wire logic        stack_underflow,
  input wire logic        debug_enable,
  input wire logic        port_pin_b6_gpio,
  input wire logic        port_pin_b7_gpio,
  input wire logic [10:0] boot_block_words,
  input wire logic        stack_reset,
  input wire logic        code_block0_wp,
  input wire logic        code_block1_wp,
  input wire logic        eeprom_wp,
  input wire logic        boot_wp,
  input wire logic        self_write_go,
  input wire logic [2:0]  self_write_region
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_debug_pins: assert property (
    port_pin_b6_gpio == !debug_enable && port_pin_b7_gpio == !debug_enable)
    else $error("debug pins disagree with debug enable");
  a_boot_size_set: assert property (boot_block_words == 11'h100 ||
    boot_block_words == 11'h200 || (LARGE_VARIANT && boot_block_words == 11'h400))
    else $error("boot size not in table");
  a_stack_quiet: assert property (
    (!stack_overflow && !stack_underflow) [*4] |-> !stack_reset)
    else $error("stack reset without fault");
  a_go_cause: assert property (
    self_write_go |-> $past(psel && !penable && pwrite && paddr == 12'h044))
    else $error("self write without request");
  a_locked_no_go: assert property (self_write_go |->
    !(self_write_region == 3'h0 && code_block0_wp ||
      self_write_region == 3'h1 && code_block1_wp ||
      self_write_region == 3'h2 && boot_wp ||
      self_write_region == 3'h3 && eeprom_wp))
    else $error("self write to locked region");
  a_go_single: assert property (self_write_go |=> !self_write_go)
    else $error("self write pulse too long");
  c_go: cover property (self_write_go);
  c_stack: cover property (stack_reset);
  c_err: cover property (pslverr);
endmodule // fuse_props
bind config_fuse_protection fuse_props #(.LARGE_VARIANT(LARGE_VARIANT)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .stack_overflow, .stack_underflow, .debug_enable, .port_pin_b6_gpio,
  .port_pin_b7_gpio, .boot_block_words, .stack_reset, .code_block0_wp,
  .code_block1_wp, .eeprom_wp, .boot_wp, .self_write_go, .self_write_region);
`default_nettype wire

/* verif/prog_model.sv */
// Programmer model: APB master that loads the configuration bytes
`timescale 1ns/1ps
`default_nettype none
module prog_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Request held until pready is seen; only the bench watchdog ends a wait
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // prog_model
`default_nettype wire

/* verif/config_fuse_protection_tb_top.sv */
// Self-checking bench for the protection configuration block
`timescale 1ns/1ps
`default_nettype none
module config_fuse_protection_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic        stack_overflow, stack_underflow, debug_enable, stack_reset;
  logic        port_pin_b6_gpio, port_pin_b7_gpio, code_block0_wp;
  logic        code_block1_wp, eeprom_wp, boot_wp, config_wp, self_write_go;
  logic [2:0]  self_write_region;
  logic [10:0] boot_block_words, small_boot_words;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          errors = 0, total_checks = 0, gos = 0;
  config_fuse_protection #(.LARGE_VARIANT(1)) u_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stack_overflow, .stack_underflow, .debug_enable, .port_pin_b6_gpio,
    .port_pin_b7_gpio, .boot_block_words, .stack_reset, .code_block0_wp,
    .code_block1_wp, .eeprom_wp, .boot_wp, .config_wp, .self_write_go,
    .self_write_region);
  // Smaller size table variant shares the bus; only its boot size is watched
  config_fuse_protection #(.LARGE_VARIANT(0)) u_dut_small (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(),
    .pslverr(), .stack_overflow, .stack_underflow, .debug_enable(),
    .port_pin_b6_gpio(), .port_pin_b7_gpio(),
    .boot_block_words(small_boot_words), .stack_reset(), .code_block0_wp(),
    .code_block1_wp(), .eeprom_wp(), .boot_wp(), .config_wp(),
    .self_write_go(), .self_write_region());
  prog_model u_prog (.pclk, .prdata, .pready, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) if (self_write_go === 1'b1) gos++;
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One extra edge so policy outputs, which lag by a cycle, have landed
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_prog.xfer(w, a, d, rdat, serr);
    @(posedge pclk);
  endtask
  task automatic t_reset;
    acc(0, 12'h018, 0);
    chk("dbs", rdat, 32'h81);
    acc(0, 12'h028, 0);
    chk("cbl", rdat, 32'h03);
    acc(0, 12'h02c, 0);
    chk("ebl", rdat, 32'he0);
    chk("dbg", debug_enable, 1'b0);
    chk("pins", {port_pin_b6_gpio, port_pin_b7_gpio}, 2'b11);
    chk("size", boot_block_words, 11'h100);
    chk("small", small_boot_words, 11'h100);
    acc(0, 12'h0f0, 0);
    chk("err", serr, 1'b1);
  endtask
  task automatic t_debug_boot;
    for (int c = 0; c < 4; c++) begin
      acc(1, 12'h018, 32'hffff_ff0f | (c << 4));
      acc(0, 12'h018, 0);
      chk("dbs", rdat, 32'h01 | (c << 4));
      chk("size", boot_block_words, c[1] ? 11'h400 : 11'h100 << c[0]);
      chk("small", small_boot_words, (c == 0) ? 11'h100 : 11'h200);
      chk("dbg", debug_enable, 1'b1);
      chk("pins", {port_pin_b6_gpio, port_pin_b7_gpio}, 2'b00);
    end
  endtask
  task automatic t_stack;
    for (int k = 0; k < 4; k++) begin
      acc(1, 12'h018, {31'h40, k[1]});
      {stack_overflow, stack_underflow} <= k[0] ? 2'b01 : 2'b10;
      repeat (4) @(posedge pclk);
      chk("srst", stack_reset, k[1]);
      {stack_overflow, stack_underflow} <= 2'b00;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic t_locks;
    acc(1, 12'h028, 32'h2);
    acc(1, 12'h028, 32'h3);
    acc(0, 12'h028, 0);
    chk("cbl", rdat, 32'h2);
    chk("cwp", {code_block1_wp, code_block0_wp}, 2'b01);
    acc(1, 12'h02c, 32'h0);
    acc(0, 12'h02c, 0);
    chk("ebl", rdat, 32'h20);
    chk("wp", {eeprom_wp, boot_wp, config_wp}, 3'b110);
    for (int r = 0; r < 5; r++) acc(1, 12'h044, r);
    acc(0, 12'h048, 0);
    chk("drops", rdat[15:8], 8'h03);
    chk("dropped", rdat[0], 1'b1);
    chk("gos", gos, 2);
    chk("region", self_write_region, 3'h4);
    acc(1, 12'h048, 1);
    acc(0, 12'h048, 0);
    chk("cleared", rdat[7:0], 8'h00);
    acc(1, 12'h040, 1);
    acc(1, 12'h02c, 0);
    acc(1, 12'h040, 0);
    acc(1, 12'h018, 32'h80);
    acc(0, 12'h018, 0);
    chk("dbs", rdat, 32'h81);
    chk("cwp", config_wp, 1'b1);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
  initial begin
    presetn = 1'b0;
    stack_overflow = 1'b0;
    stack_underflow = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_debug_boot;
    t_stack;
    t_locks;
    print_verdict;
  end
endmodule // config_fuse_protection_tb_top
`default_nettype wire
